/* File: design/dual_wiper_nv_copy_ctrl.sv */
// Serial command execution for a dual wiper potentiometer with nonvolatile backup.
// Assumes csN, sclk and din are synchronous to clk; sclk rising edges are detected.
// Functional notes
// - Copy wiper into selected nonvolatile registers.
// - Code 11 reloads selected wipers from nonvolatile.
// - Nonvolatile registers start at midscale.
// - Power-up recall within 5us before commands.
// - Standby whenever recall is done and no transaction is active.
// - Frame bits shifted MSB first on rising sclk.
// - Copy commands accept 8 or 16 clocks.
// - Execute frame on chip-select rising edge.
// - Decode write wiper, write nv, both copies.
`timescale 1ns/100ps
module dual_wiper_nv_copy_ctrl #(
    parameter int PowerUpCount = pot_pkg::PowerUpCycles
) (
    // System.
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins.
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    // Wiper positions and status.
    output logic [7:0] wiperA,
    output logic [7:0] wiperB,
    output logic [7:0] nvA,
    output logic [7:0] nvB,
    output logic standby,
    output logic initDone
);
    localparam int Channels = 2;
    localparam int CountBits = 13;
    localparam int BitCntBits = 5;
    localparam int ShortCmdHi = pot_pkg::CmdHiPos - pot_pkg::ShortFrameBits;
    localparam int ShortCmdLo = pot_pkg::CmdLoPos - pot_pkg::ShortFrameBits;
    localparam int ShortSelB = pot_pkg::SelBPos - pot_pkg::ShortFrameBits;
    localparam int ShortSelA = pot_pkg::SelAPos - pot_pkg::ShortFrameBits;

    // A recall time of zero, or one beyond the power-up budget, cannot be served.
    if (PowerUpCount < 1 || PowerUpCount > pot_pkg::PowerUpCycles) begin : g_bad_count
        $error("PowerUpCount out of range");
    end

    // The recall counter must hold the whole count.
    if (PowerUpCount >= (1 << CountBits)) begin : g_bad_width
        $error("PowerUpCount too wide for the recall counter");
    end

    // Edge detection and sequencing.
    logic sclkPrev_q;
    logic csPrev_q;
    logic sclkRise;
    logic csRise;
    pot_pkg::state_e state_q;
    logic [CountBits-1:0] initCnt_q;
    logic initLast;

    // Frame capture.
    logic [pot_pkg::LongFrameBits-1:0] shift_q;
    logic [BitCntBits-1:0] bitCnt_q;
    logic longFrame;
    logic shortFrame;
    logic execute;
    pot_pkg::frame_s frame;

    // Command decode, one strobe per action.
    logic doWriteWiper;
    logic doWriteNv;
    logic doCopyToNv;
    logic doCopyToWiper;
    logic [Channels-1:0] chanSel;

    // Per-channel values, channel A at index 0.
    logic [Channels-1:0][pot_pkg::WiperBits-1:0] wiperAll;
    logic [Channels-1:0][pot_pkg::WiperBits-1:0] nvAll;

    // The serial clock idles low, so no false edge follows reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= sclk;
        end
    end

    // Chip-select idles high, so its rising edge marks the end of a frame.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csPrev_q <= 1'b1;
        end else begin
            csPrev_q <= csN;
        end
    end

    assign sclkRise = sclk && !sclkPrev_q;
    assign csRise = csN && !csPrev_q;

    // The recall counter stops on its last count, so a chip-select held low
    // at the end of recall only delays the exit and never wraps the count.
    assign initLast = initCnt_q == CountBits'(PowerUpCount - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            initCnt_q <= '0;
        end else if (state_q == pot_pkg::ST_INIT && !initLast) begin
            initCnt_q <= initCnt_q + CountBits'(1);
        end
    end

    // Power-up recall, then standby until chip-select falls.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pot_pkg::ST_INIT;
        end else begin
            case (state_q)
                pot_pkg::ST_INIT: begin
                    // Recall is left only between frames, so no half frame is taken.
                    if (initLast && csN) begin
                        state_q <= pot_pkg::ST_STANDBY;
                    end
                end
                pot_pkg::ST_STANDBY: begin
                    if (!csN) begin
                        state_q <= pot_pkg::ST_SHIFT;
                    end
                end
                pot_pkg::ST_SHIFT: begin
                    if (csN) begin
                        state_q <= pot_pkg::ST_STANDBY;
                    end
                end
                default: begin
                    state_q <= pot_pkg::ST_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
        end else if (state_q != pot_pkg::ST_SHIFT) begin
            shift_q <= '0;
        end else if (sclkRise && !csN) begin
            shift_q <= {shift_q[pot_pkg::LongFrameBits-2:0], din};
        end
    end

    // The bit count saturates, so an overlong frame never passes for a legal one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_q <= '0;
        end else if (state_q != pot_pkg::ST_SHIFT) begin
            bitCnt_q <= '0;
        end else if (sclkRise && !csN && bitCnt_q != '1) begin
            bitCnt_q <= bitCnt_q + BitCntBits'(1);
        end
    end

    assign longFrame = bitCnt_q == BitCntBits'(pot_pkg::LongFrameBits);
    assign shortFrame = bitCnt_q == BitCntBits'(pot_pkg::ShortFrameBits);
    assign execute = csRise && state_q == pot_pkg::ST_SHIFT;

    // Short frames sit in the low byte; long frames span all sixteen bits.
    always_comb begin
        frame = '0;
        if (longFrame) begin
            frame.cmdCode = shift_q[pot_pkg::CmdHiPos:pot_pkg::CmdLoPos];
            frame.chanSelB = shift_q[pot_pkg::SelBPos];
            frame.chanSelA = shift_q[pot_pkg::SelAPos];
            frame.wiperValue = shift_q[pot_pkg::WiperBits-1:0];
        end else if (shortFrame) begin
            frame.cmdCode = shift_q[ShortCmdHi:ShortCmdLo];
            frame.chanSelB = shift_q[ShortSelB];
            frame.chanSelA = shift_q[ShortSelA];
        end
    end

    // Writes carry data and so need the long frame; copies take either length.
    always_comb begin
        doWriteWiper = 1'b0;
        doWriteNv = 1'b0;
        doCopyToNv = 1'b0;
        doCopyToWiper = 1'b0;
        if (execute) begin
            if (frame.cmdCode == pot_pkg::CmdWriteWiper) begin
                doWriteWiper = longFrame;
            end else if (frame.cmdCode == pot_pkg::CmdWriteNv) begin
                doWriteNv = longFrame;
            end else if (frame.cmdCode == pot_pkg::CmdCopyToNv) begin
                doCopyToNv = longFrame || shortFrame;
            end else if (frame.cmdCode == pot_pkg::CmdCopyToWiper) begin
                doCopyToWiper = longFrame || shortFrame;
            end
        end
    end

    assign chanSel = {frame.chanSelB, frame.chanSelA};

    for (genvar ch = 0; ch < Channels; ch++) begin : g_chan
        logic [pot_pkg::WiperBits-1:0] wiper_q;
        logic [pot_pkg::WiperBits-1:0] nv_q;

        // The wiper follows its backup during recall, then writes and reloads.
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                wiper_q <= pot_pkg::MidscaleCode;
            end else if (state_q == pot_pkg::ST_INIT) begin
                wiper_q <= nv_q;
            end else if (doWriteWiper && chanSel[ch]) begin
                wiper_q <= frame.wiperValue;
            end else if (doCopyToWiper && chanSel[ch]) begin
                wiper_q <= nv_q;
            end
        end

        // Reset stands in for the factory midscale contents of the backup.
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                nv_q <= pot_pkg::MidscaleCode;
            end else if (doWriteNv && chanSel[ch]) begin
                nv_q <= frame.wiperValue;
            end else if (doCopyToNv && chanSel[ch]) begin
                nv_q <= wiper_q;
            end
        end

        assign wiperAll[ch] = wiper_q;
        assign nvAll[ch] = nv_q;
    end

    assign wiperA = wiperAll[0];
    assign wiperB = wiperAll[1];
    assign nvA = nvAll[0];
    assign nvB = nvAll[1];
    assign standby = state_q == pot_pkg::ST_STANDBY;
    assign initDone = state_q != pot_pkg::ST_INIT;
endmodule : dual_wiper_nv_copy_ctrl

/* File: design/pot_pkg.sv */
// Package for the dual wiper nonvolatile copy controller.
// Assumes a single 200 MHz system clock and synchronous pin inputs.
package pot_pkg;
    localparam int WiperBits = 8;
    localparam logic [7:0] MidscaleCode = 8'h80;
    localparam int ClkPeriodPs = 5000;
    localparam int PowerUpTimeNs = 5000;
    localparam int PowerUpCycles = (PowerUpTimeNs * 1000) / ClkPeriodPs;
    localparam int ShortFrameBits = 8;
    localparam int LongFrameBits = 16;
    localparam int CmdHiPos = 13;
    localparam int CmdLoPos = 12;
    localparam int SelBPos = 9;
    localparam int SelAPos = 8;
    localparam logic [1:0] CmdWriteWiper = 2'h0;
    localparam logic [1:0] CmdWriteNv = 2'h1;
    localparam logic [1:0] CmdCopyToNv = 2'h2;
    localparam logic [1:0] CmdCopyToWiper = 2'h3;

    typedef struct packed {
        logic [1:0] cmdCode;
        logic chanSelB;
        logic chanSelA;
        logic [7:0] wiperValue;
    } frame_s;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_STANDBY = 3'b010,
        ST_SHIFT = 3'b100
    } state_e;
endpackage : pot_pkg

/* File: verif/pot_ctrl_assertions.sv */
// Port checker for the dual wiper nonvolatile copy controller.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps
module pot_ctrl_checker #(
    parameter int PowerUpCount = pot_pkg::PowerUpCycles
) (
    // System.
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins.
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    // Outputs.
    input wire logic [7:0] wiperA,
    input wire logic [7:0] wiperB,
    input wire logic [7:0] nvA,
    input wire logic [7:0] nvB,
    input wire logic standby,
    input wire logic initDone
);
    logic [15:0] upCnt_q;

    // Counts the cycles spent in power-up recall.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upCnt_q <= 16'h0000;
        end else if (!initDone) begin
            upCnt_q <= upCnt_q + 16'h0001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_standby_idle: assert property (
        initDone && $past(initDone) && csN && $past(csN) |-> standby)
        else $error("standby missing while idle");
    a_busy_frame: assert property ($past(initDone) && !csN && !$past(csN) |-> !standby)
        else $error("standby during frame");
    a_init_not_idle: assert property (!initDone |-> !standby)
        else $error("standby during recall");
    a_wiper_when: assert property (
        $past(initDone) && $changed({wiperA, wiperB}) |-> $past(csN) && !$past(csN, 2))
        else $error("wiper moved outside frame end");
    a_nv_when: assert property (
        $past(initDone) && $changed({nvA, nvB}) |-> $past(csN) && !$past(csN, 2))
        else $error("nv moved outside frame end");
    a_nv_midscale: assert property (!initDone |-> nvA == 8'h80 && nvB == 8'h80)
        else $error("nv not midscale at start");
    a_init_recall: assert property ($rose(initDone) |-> wiperA == nvA && wiperB == nvB)
        else $error("recall mismatch");
    a_init_bound: assert property (upCnt_q > PowerUpCount + 2 |-> initDone)
        else $error("init too slow");
    a_init_stays: assert property ($past(initDone) |-> initDone)
        else $error("init dropped");
endmodule : pot_ctrl_checker
bind dual_wiper_nv_copy_ctrl pot_ctrl_checker #(.PowerUpCount(PowerUpCount)) u_chk (
    .clk(clk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .din(din), .wiperA(wiperA),
    .wiperB(wiperB), .nvA(nvA), .nvB(nvB), .standby(standby), .initDone(initDone));

/* File: verif/spi_master_model.sv */
// Write-only serial master that drives chip-select, clock and data.
// Assumes the bench clock; pins change just after rising edges.
`timescale 1ns/100ps
module spi_master_model (
    // Bench clock.
    input wire logic clk,
    // Serial pins toward the device.
    output logic csN,
    output logic sclk,
    output logic din
);
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // Sends the top n bits of word, most significant first, two clocks per bit.
    task automatic sendFrame(input logic [15:0] word, input int n);
        @(posedge clk) csN <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            @(posedge clk) begin
                sclk <= 1'b0;
                din <= word[i];
            end
            @(posedge clk) sclk <= 1'b1;
        end
        // The data line shows the inverse of its last bit as the clock falls, one clock before chip-select rises.
        @(posedge clk) begin
            sclk <= 1'b0;
            din <= ~din;
        end
        @(posedge clk) csN <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : sendFrame
endmodule : spi_master_model

/* File: verif/testbench.sv */
// Self-checking bench for the dual wiper nonvolatile copy controller.
// Assumes the serial master model and the port checker are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin badCount++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench;
    typedef struct packed {
        logic [1:0] cmd; logic [1:0] sel; logic [7:0] data; logic [4:0] n; logic [31:0] exp;
    } row_s;
    logic clk, rst_n, csN, sclk, din, standby, initDone;
    logic [7:0] wiperA, wiperB, nvA, nvB;
    int badCount = 0;
    int samplesChecked = 0;
    row_s rows [15] = '{'{2'h0, 2'h1, 8'h3C, 5'h10, 32'h3C808080},
        '{2'h0, 2'h2, 8'hC5, 5'h10, 32'h3CC58080}, '{2'h2, 2'h3, 8'h00, 5'h08, 32'h3CC53CC5},
        '{2'h1, 2'h1, 8'h11, 5'h10, 32'h3CC511C5}, '{2'h3, 2'h1, 8'h00, 5'h08, 32'h11C511C5},
        '{2'h0, 2'h3, 8'h5A, 5'h10, 32'h5A5A11C5}, '{2'h2, 2'h2, 8'h00, 5'h10, 32'h5A5A115A},
        '{2'h3, 2'h3, 8'hFF, 5'h08, 32'h115A115A}, '{2'h0, 2'h1, 8'h77, 5'h08, 32'h115A115A},
        '{2'h2, 2'h3, 8'h00, 5'h0C, 32'h115A115A}, '{2'h0, 2'h3, 8'h99, 5'h10, 32'h9999115A},
        '{2'h3, 2'h2, 8'hAA, 5'h10, 32'h995A115A}, '{2'h1, 2'h0, 8'h33, 5'h10, 32'h995A115A},
        '{2'h1, 2'h3, 8'h44, 5'h10, 32'h995A4444}, '{2'h2, 2'h1, 8'hEE, 5'h10, 32'h995A9944}};
    dual_wiper_nv_copy_ctrl #(.PowerUpCount(4)) u_dual_wiper_nv_copy_ctrl (.clk(clk),
        .rst_n(rst_n), .csN(csN), .sclk(sclk), .din(din), .wiperA(wiperA), .wiperB(wiperB),
        .nvA(nvA), .nvB(nvB), .standby(standby), .initDone(initDone));
    spi_master_model u_spi_master_model (.clk(clk), .csN(csN), .sclk(sclk), .din(din));
    task automatic summarize();
        $display("checks %0d errors %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic waitIdle();
        for (int i = 0; i < 40 && standby !== 1'b1; i++) @(posedge clk);
        #1;
    endtask : waitIdle
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // The tests need well under a thousand cycles; this span only catches a hang.
    initial begin
        repeat (5000) @(posedge clk);
        badCount++;
        summarize();
    end
    initial begin
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        `CHK({wiperA, wiperB, nvA, nvB}, 32'h80808080)
        rst_n <= 1'b1;
        waitIdle();
        `CHK({initDone, standby}, 2'h3)
        foreach (rows[i]) begin
            u_spi_master_model.sendFrame({2'h0, rows[i].cmd, 2'h0, rows[i].sel, rows[i].data},
                int'(rows[i].n));
            `CHK({wiperA, wiperB, nvA, nvB}, rows[i].exp)
        end
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        `CHK({initDone, standby}, 2'h0)
        waitIdle();
        `CHK({wiperA, wiperB, nvA, nvB}, 32'h80808080)
        summarize();
    end
endmodule : testbench
